//--- lcc_regs.vh
// register map and field layout of the configurable logic cell
// assumes a 32-bit classic wishbone slave with byte addressing
`ifndef LCC_REGS_VH
`define LCC_REGS_VH

`define LCC_ADR_W            8
`define LCC_OFF_MASK         8'h00
`define LCC_OFF_CFG          8'h04
`define LCC_OFF_STAT         8'h08

`define LCC_MASK_RST         16'h0000
`define LCC_CFG_RST          11'h000
`define LCC_CFG_W            11

`define LCC_CFG_MODE_LO      0
`define LCC_CFG_MODE_HI      1
`define LCC_CFG_CIN_SEL      2
`define LCC_CFG_CASC_EN      3
`define LCC_CFG_CASC_OR      4
`define LCC_CFG_SRC_LO       5
`define LCC_CFG_SRC_HI       6
`define LCC_CFG_TAP_LO       7
`define LCC_CFG_TAP_HI       8
`define LCC_CFG_LOC_REG      9
`define LCC_CFG_GLB_REG      10

`define LCC_MODE_NORMAL      2'h0
`define LCC_MODE_ARITH       2'h1
`define LCC_MODE_COUNT       2'h2

`define LCC_SRC_COMB         2'h0
`define LCC_SRC_FOURTH       2'h1
`define LCC_SRC_TAP          2'h2

`define LCC_STAT_Q           0
`define LCC_STAT_COMB        1
`define LCC_STAT_COUT        2
`define LCC_STAT_CASC        3

`endif

//--- lcc_lut.v
// lookup table: mask bit picked by the select word
// assumes mask and select come from logic on the same clock
`timescale 1ns/1ps
module lcc_lut #(
  parameter IN_W = 4
) (
  input  wire [(1<<IN_W)-1:0] mask_i,
  input  wire [IN_W-1:0]      sel_i,
  output wire                 out_o
);
  assign out_o = mask_i[sel_i];
endmodule // lcc_lut

//--- lcc_cell_reg.v
// programmable cell register with clock enable, async clear and preset
// assumes clear and preset are glitch-free levels from cell_cluster logic
`timescale 1ns/1ps
module lcc_cell_reg (
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  input  wire clr_i,
  input  wire pre_i,
  input  wire d_i,
  output reg  q_o
);
  reg q_reg;

  // clear beats preset when both are raised
  always @(posedge clk_i or posedge clr_i or posedge pre_i)
  begin
    if (clr_i)
      q_reg <= 1'b0;
    else if (pre_i)
      q_reg <= 1'b1;
    else if (rst_i)
      q_reg <= 1'b0;
    else if (ce_i)
      q_reg <= d_i;
  end

  // level override: a preset still held when clear drops shows at once
  always @*
  begin
    if (clr_i)
      q_o = 1'b0;
    else if (pre_i)
      q_o = 1'b1;
    else
      q_o = q_reg;
  end
endmodule // lcc_cell_reg

//--- lcc_logic_cell.v
// logic_cell top: cell datapath plus classic wishbone configuration slave
// assumes cell inputs come from cell_cluster logic on clk_i, no synchronisers
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "lcc_regs.vh"
module lcc_logic_cell (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [3:0]  cell_data_i,
  input  wire        carry_in_i,
  input  wire        cascade_in_i,
  input  wire        cell_ce_i,
  input  wire        cell_clr_i,
  input  wire        cell_pre_i,
  output wire        carry_out_o,
  output wire        cascade_out_o,
  output wire        local_out_o,
  output wire        global_out_o
);

  // byte-lane merge shared by both writable registers
  function [31:0] wb_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer      k;
    begin
      wb_merge = old_v;
      for (k = 0; k < 4; k = k + 1)
        if (sel[k])
          wb_merge[k*8 +: 8] = new_v[k*8 +: 8];
    end
  endfunction

  // counter mode reroutes both split tables and the register source
  function is_count;
    input [1:0] m;
    begin
      is_count = (m == `LCC_MODE_COUNT);
    end
  endfunction

  // routing pick shared by the local and global outputs
  function route_pick;
    input from_q;
    input q;
    input chain;
    begin
      if (from_q)
        route_pick = q;
      else
        route_pick = chain;
    end
  endfunction

  // cascade merge; and-chain for wide decodes, or-chain for sums of terms
  function cascade_merge;
    input en;
    input use_or;
    input val;
    input cas_in;
    begin
      if (!en)
        cascade_merge = val;
      else if (use_or)
        cascade_merge = val | cas_in;
      else
        cascade_merge = val & cas_in;
    end
  endfunction

  // truth tables and mode live in flops written over the bus
  reg  [15:0]           mask_reg;
  reg  [15:0]           mask_next;
  reg  [`LCC_CFG_W-1:0] cfg_reg;
  reg  [`LCC_CFG_W-1:0] cfg_next;
  reg  [31:0]           dat_next;
  reg                   ack_next;
  reg  [31:0]           merged;

  wire                  bus_req;
  wire                  bus_wr;
  wire [1:0]            mode;
  wire                  cin_sel;
  wire                  casc_en;
  wire                  casc_or;
  wire [1:0]            reg_src;
  wire [1:0]            tap_idx;
  wire                  loc_reg;
  wire                  glb_reg;

  // cell datapath nets
  wire                  third_data_input;
  wire                  fourth_data_input;
  wire                  lut_in3;
  wire [3:0]            lut4_sel;
  wire [2:0]            arith_sel;
  wire [2:0]            count_sel;
  wire [2:0]            lo_sel;
  wire                  lut4_out;
  wire                  lo_out;
  wire                  hi_out;
  wire                  cell_q;

  // results of the combinational datapath processes
  reg                   comb_out;
  reg                   chain_out;
  reg                   carry_out;
  reg                   reg_d;

  // counter controls ride on the data pins, no extra inputs needed
  wire                  cnt_en;
  wire                  cnt_dir;
  wire                  cnt_load_data;
  wire                  cnt_load;

  // wishbone decode; one-cycle answer, ack never held two cycles
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i;

  // write side: byte-lane merge into the addressed register
  always @*
  begin
    mask_next = mask_reg;
    cfg_next  = cfg_reg;
    merged    = 32'h00000000;
    ack_next  = bus_req;
    case (wb_adr_i)
      `LCC_OFF_MASK:
      begin
        merged = wb_merge({16'h0000, mask_reg}, wb_dat_i, wb_sel_i);
        if (bus_wr)
          mask_next = merged[15:0];
      end
      `LCC_OFF_CFG:
      begin
        merged = wb_merge({21'h000000, cfg_reg}, wb_dat_i, wb_sel_i);
        if (bus_wr)
          cfg_next = merged[`LCC_CFG_W-1:0];
      end
      default:
      begin
        // status and unmapped: answered, writes dropped
        merged = 32'h00000000;
      end
    endcase
  end

  // read side: zero outside a read so the bus shows no stale data
  always @*
  begin
    dat_next = 32'h00000000;
    case (wb_adr_i)
      `LCC_OFF_MASK: dat_next = {16'h0000, mask_reg};
      `LCC_OFF_CFG:  dat_next = {21'h000000, cfg_reg};
      `LCC_OFF_STAT: dat_next = {28'h0000000, chain_out, carry_out, comb_out, cell_q};
      default:       dat_next = 32'h00000000;
    endcase
    if (!bus_req || wb_we_i)
      dat_next = 32'h00000000;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      mask_reg <= `LCC_MASK_RST;
    else
      mask_reg <= mask_next;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      cfg_reg <= `LCC_CFG_RST;
    else
      cfg_reg <= cfg_next;
  end

  // ack and read data share one process so they can never skew
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h00000000;
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_dat_o <= dat_next;
      wb_ack_o <= ack_next;
    end
  end

  // configuration fields
  assign mode    = cfg_reg[`LCC_CFG_MODE_HI:`LCC_CFG_MODE_LO];
  assign cin_sel = cfg_reg[`LCC_CFG_CIN_SEL];
  assign casc_en = cfg_reg[`LCC_CFG_CASC_EN];
  assign casc_or = cfg_reg[`LCC_CFG_CASC_OR];
  assign reg_src = cfg_reg[`LCC_CFG_SRC_HI:`LCC_CFG_SRC_LO];
  assign tap_idx = cfg_reg[`LCC_CFG_TAP_HI:`LCC_CFG_TAP_LO];
  assign loc_reg = cfg_reg[`LCC_CFG_LOC_REG];
  assign glb_reg = cfg_reg[`LCC_CFG_GLB_REG];

  // named taps of the data bus
  assign third_data_input  = cell_data_i[2];
  assign fourth_data_input = cell_data_i[3];

  // table input three is carry-in or the third data input
  assign lut_in3  = cin_sel ? carry_in_i : third_data_input;
  assign lut4_sel = {fourth_data_input, lut_in3, cell_data_i[1], cell_data_i[0]};

  // counter controls: d0 enable, d1 direction, d2 load value, d3 load strobe
  assign cnt_en        = cell_data_i[0];
  assign cnt_dir       = cell_data_i[1];
  assign cnt_load_data = third_data_input;
  assign cnt_load      = fourth_data_input;

  assign arith_sel = {carry_in_i, cell_data_i[1], cell_data_i[0]};
  // feedback from the register closes the counting loop
  assign count_sel = {carry_in_i, cnt_dir, cell_q};
  assign lo_sel    = is_count(mode) ? count_sel : arith_sel;

  lcc_lut #(
    .IN_W (4)
  ) u_lut4 (
    .mask_i (mask_reg),
    .sel_i  (lut4_sel),
    .out_o  (lut4_out)
  );

  // split halves: low byte is the value table, high byte the carry table
  lcc_lut #(
    .IN_W (3)
  ) u_lut_lo (
    .mask_i (mask_reg[7:0]),
    .sel_i  (lo_sel),
    .out_o  (lo_out)
  );

  lcc_lut #(
    .IN_W (3)
  ) u_lut_hi (
    .mask_i (mask_reg[15:8]),
    .sel_i  (lo_sel),
    .out_o  (hi_out)
  );

  // table result, cascade merge and carry per mode
  always @*
  begin
    comb_out  = lut4_out;
    carry_out = 1'b0;
    case (mode)
      `LCC_MODE_NORMAL:
      begin
        comb_out  = lut4_out;
        carry_out = 1'b0;
      end
      `LCC_MODE_ARITH:
      begin
        comb_out  = lo_out;
        carry_out = hi_out;
      end
      `LCC_MODE_COUNT:
      begin
        comb_out  = lo_out;
        carry_out = hi_out;
      end
      default:
      begin
        comb_out  = lut4_out;
        carry_out = 1'b0;
      end
    endcase
    // cascade stays usable in every mode, arithmetic included
    chain_out = cascade_merge(casc_en, casc_or, comb_out, cascade_in_i);
  end

  // register data source; packing never bypasses ce, clear or preset
  always @*
  begin
    reg_d = chain_out;
    if (is_count(mode))
    begin
      if (cnt_load)
        reg_d = cnt_load_data;
      else if (cnt_en)
        reg_d = lo_out;
      else
        reg_d = cell_q;
    end
    else
    begin
      case (reg_src)
        `LCC_SRC_COMB:  reg_d = chain_out;
        `LCC_SRC_FOURTH: reg_d = fourth_data_input;
        `LCC_SRC_TAP:   reg_d = lut4_sel[tap_idx];
        default:        reg_d = chain_out;
      endcase
    end
  end

  // async clear and preset stay inside the register, off the table path
  lcc_cell_reg u_reg (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (cell_ce_i),
    .clr_i (cell_clr_i),
    .pre_i (cell_pre_i),
    .d_i   (reg_d),
    .q_o   (cell_q)
  );

  // routing outputs stay combinational so chains keep one-cell latency
  assign local_out_o   = route_pick(loc_reg, cell_q, chain_out);
  assign global_out_o  = route_pick(glb_reg, cell_q, chain_out);
  assign cascade_out_o = chain_out;
  assign carry_out_o   = carry_out;

endmodule // lcc_logic_cell

//--- lcc_nbr_model.sv
// upstream neighbour cell: drives the carry and cascade chain inputs
// assumes the bench sets the next chain values just after a clock edge
`timescale 1ns/1ps
module lcc_nbr_model (
  input  wire       clk_i,
  input  wire [1:0] drive_i,
  output reg        carry_o = 1'b0,
  output reg        cascade_o = 1'b0
);
  // registered like a real upstream cell, so chain values move only on edges
  always @(posedge clk_i)
  begin
    carry_o   <= drive_i[0];
    cascade_o <= drive_i[1];
  end
endmodule // lcc_nbr_model

//--- lcc_logic_cell_assertions.sv
// checker: bus handshake and cell output relations
// assumes full-word writes; byte lane merging is not tracked here
`timescale 1ns/1ps
module lcc_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire [3:0]  cell_data_i,
  input wire        carry_in_i,
  input wire        cell_ce_i,
  input wire        cell_clr_i,
  input wire        cell_pre_i,
  input wire        carry_out_o,
  input wire        local_out_o,
  input wire        global_out_o
);
  reg  [15:0] m_sh;
  reg  [10:0] c_sh;
  wire        wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire [3:0]  n4 = {cell_data_i[3], c_sh[2] ? carry_in_i : cell_data_i[2], cell_data_i[1:0]};
  wire [2:0]  a3 = {carry_in_i, cell_data_i[1:0]};
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      m_sh <= 16'h0000;
      c_sh <= 11'h000;
    end
    else if (wr && wb_adr_i == 8'h00)
      m_sh <= wb_dat_i[15:0];
    else if (wr && wb_adr_i == 8'h04)
      c_sh <= wb_dat_i[10:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_normal_lut: assert property (c_sh[1:0] == 2'h0 && !c_sh[3] && !c_sh[9]
    |-> local_out_o == m_sh[n4]) else $error("normal table output wrong");
  a_normal_carry: assert property (c_sh[1:0] == 2'h0 |-> !carry_out_o)
    else $error("carry out set in normal mode");
  a_arith_sum: assert property (c_sh[1:0] == 2'h1 && !c_sh[3] && !c_sh[10]
    |-> global_out_o == m_sh[{1'b0, a3}]) else $error("sum output wrong");
  a_arith_carry: assert property (c_sh[1:0] == 2'h1
    |-> carry_out_o == m_sh[{1'b1, a3}]) else $error("arith carry wrong");
  a_clr_wins: assert property (cell_clr_i && c_sh[10] |-> !global_out_o)
    else $error("clear not forcing register low");
  a_pre_sets: assert property (cell_pre_i && !cell_clr_i && c_sh[10] |-> global_out_o)
    else $error("preset not forcing register high");
  a_ce_hold: assert property (!cell_ce_i && c_sh[9] ##1 !cell_clr_i && !cell_pre_i
    && $stable(c_sh) |-> $stable(local_out_o)) else $error("register moved without enable");
  a_count_carry: assert property (c_sh[1:0] == 2'h2 && c_sh[9]
    |-> carry_out_o == m_sh[{1'b1, carry_in_i, cell_data_i[1], local_out_o}])
    else $error("counter carry wrong");
endmodule // lcc_chk
bind lcc_logic_cell lcc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cell_data_i(cell_data_i),
  .carry_in_i(carry_in_i), .cell_ce_i(cell_ce_i), .cell_clr_i(cell_clr_i),
  .cell_pre_i(cell_pre_i), .carry_out_o(carry_out_o), .local_out_o(local_out_o),
  .global_out_o(global_out_o));

//--- test_lcc_logic_cell.sv
// testbench: register access and all cell modes of lcc_logic_cell
// assumes the neighbour model drives the chain inputs one edge late
`timescale 1ns/1ps
`include "lcc_regs.vh"
module test_lcc_logic_cell;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  data = 4'h0;
  logic [1:0]  drv = 2'h0;
  logic        ce = 1'b0;
  logic        clr = 1'b0;
  logic        pre = 1'b0;
  logic [31:0] rdat;
  logic [15:0] m;
  logic [3:0]  idx;
  logic        lut, ch, nx, qx;
  logic [4:0]  tbl [8] = '{5'h11, 5'h11, 5'h10, 5'h13, 5'h0C, 5'h09, 5'h01, 5'h13};
  wire  [31:0] dat_o;
  wire         ack, cin, cas, cout, casc_o, loc, glb;
  int          n_mismatch = 0;
  int          checks = 0;
  int          ncyc = 0;
  lcc_logic_cell dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .cell_data_i(data), .carry_in_i(cin), .cascade_in_i(cas),
    .cell_ce_i(ce), .cell_clr_i(clr), .cell_pre_i(pre), .carry_out_o(cout),
    .cascade_out_o(casc_o), .local_out_o(loc), .global_out_o(glb));
  lcc_nbr_model nbr (.clk_i(clk_i), .drive_i(drv), .carry_o(cin), .cascade_o(cas));
  always #4 clk_i = ~clk_i;
  task give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    ncyc++;
    if (ncyc > 5000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    rdat = dat_o;
    cyc <= 1'b0;
  endtask
  // ce stays low here, so the two edges never load the register
  task put(input logic [3:0] d, input logic [1:0] c);
    drv <= c;
    @(posedge clk_i);
    data <= d;
    @(posedge clk_i);
  endtask
  task tick();
    ce <= 1'b1;
    @(posedge clk_i);
    ce <= 1'b0;
    @(posedge clk_i);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `LCC_OFF_CFG, 0);
    chk("cfg_rst", rdat, {21'h0, `LCC_CFG_RST});
    wb(1, `LCC_OFF_CFG, 32'hFFFFFFFF);
    wb(0, `LCC_OFF_CFG, 0);
    chk("cfg_rw", rdat, 32'h7FF);
    wb(1, 8'h0C, 32'h1);
    wb(0, 8'h0C, 0);
    chk("unmapped", rdat, 32'h0);
    m = 16'hE896;
    wb(1, `LCC_OFF_MASK, {16'hFFFF, m});
    wb(0, `LCC_OFF_MASK, 0);
    chk("mask_rw", rdat, {16'h0, m});
    for (int md = 0; md < 2; md++)
      for (int k = 0; k < 8; k++)
      begin
        wb(1, `LCC_OFF_CFG, {27'h0, k[2:0], 1'b0, md[0]});
        for (int i = 0; i < 64; i++)
        begin
          put(i[3:0], i[5:4]);
          idx = md ? {1'b0, i[4], i[1:0]} : (k[0] ? {i[3], i[4], i[1:0]} : i[3:0]);
          lut = m[idx];
          ch = !k[1] ? lut : (k[2] ? lut | i[5] : lut & i[5]);
          chk("chain", {casc_o, cout}, {ch, md ? m[{1'b1, idx[2:0]}] : 1'b0});
          if (!k[1])
            chk("lut", {loc, glb}, {lut, lut});
        end
      end
    wb(1, `LCC_OFF_CFG, 32'h420);
    put(4'h8, 2'h0);
    chk("packed_hold", {loc, glb}, {m[8], 1'b0});
    tick();
    chk("packed_d4", {loc, glb}, {m[8], 1'b1});
    clr <= 1'b1;
    pre <= 1'b1;
    @(posedge clk_i);
    chk("clr_wins", glb, 1'b0);
    clr <= 1'b0;
    @(posedge clk_i);
    chk("preset", glb, 1'b1);
    pre <= 1'b0;
    wb(1, `LCC_OFF_CFG, 32'h2C0);
    put(4'h5, 2'h0);
    tick();
    chk("tap_lo", {loc, glb}, {1'b0, m[5]});
    put(4'hA, 2'h0);
    tick();
    chk("tap_hi", {loc, glb}, {1'b1, m[10]});
    m = 16'h605A;
    wb(1, `LCC_OFF_MASK, {16'h0, m});
    wb(1, `LCC_OFF_CFG, 32'h202);
    qx = 1'b1;
    foreach (tbl[j])
    begin
      put(tbl[j][3:0], {1'b0, tbl[j][4]});
      chk("cnt_carry", cout, m[{1'b1, tbl[j][4], tbl[j][1], qx}]);
      nx = tbl[j][3] ? tbl[j][2] : (tbl[j][0] ? m[{1'b0, tbl[j][4], tbl[j][1], qx}] : qx);
      tick();
      qx = nx;
      chk("cnt_q", loc, qx);
    end
    wb(0, `LCC_OFF_STAT, 0);
    chk("stat_q", rdat[0], qx);
    give_verdict();
  end
endmodule // test_lcc_logic_cell
